// [sax_regs.svh]
// Register indices, reset values and timing counts of the auxiliary block
`ifndef SAX_REGS_SVH
`define SAX_REGS_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define SAX_IDX_ACCEL    12'h310
`define SAX_IDX_DECEL    12'h311
`define SAX_IDX_JOG_SPD  12'h500
`define SAX_IDX_CMD      12'h600
`define SAX_IDX_STATUS   12'h601
`define SAX_IDX_PJ_DIST  12'h602
`define SAX_IDX_PJ_SPD   12'h603
`define SAX_IDX_PJ_WAIT  12'h604
`define SAX_IDX_PJ_CNT   12'h605
`define SAX_IDX_SPD_OFS  12'h606
`define SAX_IDX_TRQ_OFS  12'h607
`define SAX_IDX_CUR_U    12'h608
`define SAX_IDX_CUR_V    12'h609

// ==========================================================
// Reset values and limits
`define SAX_RST_ACCEL    16'h0000
`define SAX_RST_DECEL    16'h0000
`define SAX_RST_JOG_SPD  16'h01f4
`define SAX_JOG_MAX      16'h03e8
`define SAX_TIME_MAX     16'h2710
`define SAX_MAX_RPM      16'h0bb8
`define SAX_PJ_MODE_POS  17
`define SAX_PJ_MODE_LSB  16

// ==========================================================
// Timing
`define SAX_CLK_NS       5
`define SAX_CTRL_NS      1000000
`define SAX_CTRL_CYC     (`SAX_CTRL_NS / `SAX_CLK_NS)
`define SAX_OFS_SAMPLES  5'h10

`endif

// [sax_pkg.sv]
// Types shared by the auxiliary jog and offset block
package sax_pkg;

   // =======================================================
   // Enumerations
   typedef enum logic [2:0] {
      ST_IDLE    = 3'b000,
      ST_JOG     = 3'b001,
      ST_PJ_MOVE = 3'b010,
      ST_PJ_WAIT = 3'b011,
      ST_OFS_CMD = 3'b100,
      ST_OFS_CUR = 3'b101
   } sax_st_t;

   typedef enum logic [3:0] {
      CMD_STOP    = 4'h0,
      CMD_RESTORE = 4'h1,
      CMD_JOG_FWD = 4'h2,
      CMD_JOG_REV = 4'h3,
      CMD_PJOG    = 4'h4,
      CMD_OFS_CMD = 4'h5,
      CMD_OFS_CUR = 4'h6
   } sax_cmd_t;

   // =======================================================
   // Carriers
   typedef struct packed {
      logic [15:0] speed_cmd;
      logic [15:0] pos_step;
      logic        speed_mode;
      logic        pos_mode;
      logic        ext_pulse_en;
      logic        overtravel_en;
   } sax_loop_t;

   typedef struct packed {
      logic [15:0] spd;
      logic [15:0] trq;
      logic [15:0] cur_u;
      logic [15:0] cur_v;
   } sax_ofs_t;

   typedef struct packed {
      sax_st_t     st;
      logic [15:0] accel;
      logic [15:0] decel;
      logic [15:0] jog_spd;
      logic [31:0] pj_dist;
      logic [15:0] pj_spd;
      logic [15:0] pj_wait;
      logic [15:0] pj_cnt;
      logic [1:0]  pj_mode;
      sax_ofs_t    ofs;
      logic        refused;
      logic        restore_pend;
      logic        stopping;
      logic        dir;
      logic [31:0] vel;
      logic [31:0] rem;
      logic [15:0] wait_cnt;
      logic [15:0] rep;
      logic [17:0] tick_cnt;
      logic [4:0]  samp;
      logic [19:0] sum_a;
      logic [19:0] sum_b;
      logic [2:0]  lf;
      logic [2:0]  lr;
      logic        lim_f;
      logic        lim_r;
      sax_loop_t   loop;
      logic        nv_store;
      logic        nv_restore;
      logic        pready;
      logic [31:0] prdata;
      logic        pslverr;
   } sax_state_t;

endpackage : sax_pkg

// [sax_aux_top.sv]
// Auxiliary functions: factory restore, jogs, command and current offsets
//
// Overview of operation
// - Factory restore is refused while servo is on.
// - Restored values take effect only after a power cycle.
// - Factory restore leaves all adjusted offsets untouched.
// - Jog runs speed control from an internal speed command.
// - Jog request is refused while motor already runs normally.
// - Jog speed 0 to 1000 rpm, default 500, applies immediately.
// - Acceleration time 0 to 10000 ms, zero to maximum speed.
// - Acceleration time scales with target over maximum speed.
// - Deceleration time 0 to 10000 ms, scaled the same way.
// - Overtravel stop is disabled during speed jog.
// - Programmed jog repeats moves from preset mode, distance, speed, wait, count.
// - Programmed jog runs position control with gear and command filter.
// - External pulse commands are ignored during programmed jog.
// - Overtravel stop stays active during programmed jog.
// - Auto command offset is measured and stored in nonvolatile memory.
// - Speed command offset can be written directly.
// - Torque command offset can be written independently.
// - Separate U and V current offsets are provided.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`include "sax_regs.svh"

module sax_aux_top
   import sax_pkg::*;
#(
   parameter int CTRL_CYC = `SAX_CTRL_CYC
)
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [13:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        servo_on,
   input  wire logic        motor_running,
   input  wire logic [15:0] analog_cmd,
   input  wire logic [15:0] cur_u_adc,
   input  wire logic [15:0] cur_v_adc,
   input  wire logic        limit_fwd_pin,
   input  wire logic        limit_rev_pin,
   output sax_loop_t        loop,
   output sax_ofs_t         ofs,
   output logic             nv_store,
   output logic             nv_restore
);

   // ========================================================
   // Helpers
   function automatic logic [15:0] sax_clamp(input logic [15:0] v,
                                             input logic [15:0] mx);
      return (v > mx) ? mx : v;
   endfunction : sax_clamp

   // Constant slope means shorter swings take proportionally less time
   function automatic logic [31:0] sax_ramp_step(input logic [15:0] t);
      logic [31:0] full;
      full = {`SAX_MAX_RPM, 16'h0000};
      return (t == 16'h0000) ? full : full / {16'h0000, t};
   endfunction : sax_ramp_step

   function automatic logic [31:0] sax_approach(input logic [31:0] v,
                                                input logic [31:0] t,
                                                input logic [31:0] up,
                                                input logic [31:0] dn);
      logic [31:0]        stp;
      logic signed [32:0] nx;
      logic signed [32:0] tg;
      tg = $signed({t[31], t});
      if ($signed(v) < $signed(t))
      begin
         stp = ($signed(v) >= 0) ? up : dn;
         nx  = $signed({v[31], v}) + $signed({1'b0, stp});
         if (nx > tg)
            nx = tg;
      end
      else
      begin
         stp = ($signed(v) <= 0) ? up : dn;
         nx  = $signed({v[31], v}) - $signed({1'b0, stp});
         if (nx < tg)
            nx = tg;
      end
      return nx[31:0];
   endfunction : sax_approach

   function automatic logic sax_hit(input logic [11:0] i);
      return i inside {`SAX_IDX_ACCEL, `SAX_IDX_DECEL, `SAX_IDX_JOG_SPD,
                       `SAX_IDX_CMD, `SAX_IDX_STATUS, `SAX_IDX_PJ_DIST,
                       `SAX_IDX_PJ_SPD, `SAX_IDX_PJ_WAIT, `SAX_IDX_PJ_CNT,
                       `SAX_IDX_SPD_OFS, `SAX_IDX_TRQ_OFS, `SAX_IDX_CUR_U,
                       `SAX_IDX_CUR_V};
   endfunction : sax_hit

   // ========================================================
   // State
   sax_state_t  s;
   sax_state_t  n;
   logic        tick;
   logic        acc_ph;
   logic        wr;
   logic        cmd_go;
   logic [11:0] idx;
   logic [31:0] rdata;
   logic [31:0] up_stp;
   logic [31:0] dn_stp;
   logic [31:0] tgt;
   logic [15:0] mag;
   logic [47:0] brake;
   logic [31:0] step;
   logic        lim_hit;

   assign prdata     = s.prdata;
   assign pready     = s.pready;
   assign pslverr    = s.pslverr;
   assign loop       = s.loop;
   assign ofs        = s.ofs;
   assign nv_store   = s.nv_store;
   assign nv_restore = s.nv_restore;

   always_comb
   begin
      n       = s;
      tick    = 1'b0;
      acc_ph  = 1'b0;
      wr      = 1'b0;
      cmd_go  = 1'b0;
      idx     = paddr[13:2];
      rdata   = 32'h0;
      up_stp  = sax_ramp_step(s.accel);
      dn_stp  = sax_ramp_step(s.decel);
      tgt     = 32'h0;
      mag     = s.vel[31:16];
      brake   = 48'h0;
      step    = 32'h0;
      lim_hit = 1'b0;
      n.nv_store   = 1'b0;
      n.nv_restore = 1'b0;
      n.loop.pos_step = 16'h0000;

      // =====================================================
      // Limit pins: three stages, change accepted on agreement
      n.lf = {s.lf[1:0], limit_fwd_pin};
      n.lr = {s.lr[1:0], limit_rev_pin};
      if (s.lf[1] == s.lf[2])
         n.lim_f = s.lf[2];
      if (s.lr[1] == s.lr[2])
         n.lim_r = s.lr[2];

      // =====================================================
      // Control cycle tick
      tick = (s.tick_cnt == 18'(CTRL_CYC - 1));
      n.tick_cnt = tick ? 18'h0_0000 : s.tick_cnt + 18'h0_0001;

      // =====================================================
      // APB slave: one wait state, write lands on the pready edge
      acc_ph   = psel & penable & s.pready;
      wr       = acc_ph & pwrite;
      n.pready = psel & penable & ~s.pready;
      case (idx)
         `SAX_IDX_ACCEL:   rdata = 32'(s.accel);
         `SAX_IDX_DECEL:   rdata = 32'(s.decel);
         `SAX_IDX_JOG_SPD: rdata = 32'(s.jog_spd);
         `SAX_IDX_STATUS:  rdata = {s.loop.speed_cmd, 9'h000, s.lim_r, s.lim_f,
                                    s.restore_pend, s.refused, s.st};
         `SAX_IDX_PJ_DIST: rdata = s.pj_dist;
         `SAX_IDX_PJ_SPD:  rdata = 32'(s.pj_spd);
         `SAX_IDX_PJ_WAIT: rdata = 32'(s.pj_wait);
         `SAX_IDX_PJ_CNT:  rdata = {14'h0000, s.pj_mode, s.pj_cnt};
         `SAX_IDX_SPD_OFS: rdata = 32'(s.ofs.spd);
         `SAX_IDX_TRQ_OFS: rdata = 32'(s.ofs.trq);
         `SAX_IDX_CUR_U:   rdata = 32'(s.ofs.cur_u);
         `SAX_IDX_CUR_V:   rdata = 32'(s.ofs.cur_v);
         default:          rdata = 32'h0;
      endcase
      if (psel & penable & ~s.pready)
      begin
         n.prdata  = pwrite ? 32'h0 : rdata;
         n.pslverr = ~sax_hit(idx);
      end
      else
         n.pslverr = 1'b0;
      if (wr)
      begin
         case (idx)
            `SAX_IDX_ACCEL:   n.accel = sax_clamp(pwdata[15:0], `SAX_TIME_MAX);
            `SAX_IDX_DECEL:   n.decel = sax_clamp(pwdata[15:0], `SAX_TIME_MAX);
            `SAX_IDX_JOG_SPD: n.jog_spd = sax_clamp(pwdata[15:0], `SAX_JOG_MAX);
            `SAX_IDX_CMD:     cmd_go = 1'b1;
            `SAX_IDX_PJ_DIST: n.pj_dist = pwdata;
            `SAX_IDX_PJ_SPD:  n.pj_spd = sax_clamp(pwdata[15:0], `SAX_MAX_RPM);
            `SAX_IDX_PJ_WAIT: n.pj_wait = pwdata[15:0];
            `SAX_IDX_PJ_CNT:
            begin
               n.pj_cnt  = pwdata[15:0];
               n.pj_mode = pwdata[`SAX_PJ_MODE_POS:`SAX_PJ_MODE_LSB];
            end
            `SAX_IDX_SPD_OFS: n.ofs.spd = pwdata[15:0];
            `SAX_IDX_TRQ_OFS: n.ofs.trq = pwdata[15:0];
            `SAX_IDX_CUR_U:   n.ofs.cur_u = pwdata[15:0];
            `SAX_IDX_CUR_V:   n.ofs.cur_v = pwdata[15:0];
            default: ;
         endcase
      end

      // =====================================================
      // Motion and measurement, once per control cycle
      if (tick)
      begin
         unique case (s.st)
            ST_IDLE: ;
            ST_JOG:
            begin
               // Speed held live from the setting, so edits act at once
               if (!s.stopping)
               begin
                  tgt = {s.jog_spd, 16'h0000};
                  tgt = s.dir ? -tgt : tgt;
               end
               n.vel = sax_approach(s.vel, tgt, up_stp, dn_stp);
               if (!servo_on || (s.stopping && n.vel == 32'h0000_0000))
               begin
                  n.vel = 32'h0000_0000;
                  n.st  = ST_IDLE;
               end
            end
            ST_PJ_MOVE:
            begin
               // Braking distance v*v*Tdec/(2*max), in command units
               brake = (48'(mag) * 48'(mag) * 48'(s.decel))
                       / 48'({`SAX_MAX_RPM, 1'b0});
               if (!s.stopping && 48'(s.rem) > brake)
                  tgt = {s.pj_spd, 16'h0000};
               n.vel = sax_approach(s.vel, tgt, up_stp, dn_stp);
               // Crawl at one unit so a short move still finishes
               step = {16'h0000, n.vel[31:16]};
               if (step == 32'h0 && !s.stopping)
                  step = 32'h1;
               if (step > s.rem)
                  step = s.rem;
               n.rem = s.rem - step;
               n.loop.pos_step = s.dir ? -step[15:0] : step[15:0];
               lim_hit = s.dir ? s.lim_r : s.lim_f;
               if (lim_hit || !servo_on)
               begin
                  n.vel = 32'h0000_0000;
                  n.loop.pos_step = 16'h0000;
                  n.st  = ST_IDLE;
               end
               else if (n.rem == 32'h0000_0000 || (s.stopping && step == 32'h0000_0000))
               begin
                  n.vel = 32'h0000_0000;
                  if (s.stopping || s.rep <= 16'h0001)
                  begin
                     n.st = ST_IDLE;
                  end
                  else
                  begin
                     n.rep      = s.rep - 16'h0001;
                     n.wait_cnt = s.pj_wait;
                     n.st       = ST_PJ_WAIT;
                     if (s.pj_mode == 2'b10)
                        n.dir = ~s.dir;
                  end
               end
            end
            ST_PJ_WAIT:
            begin
               if (s.wait_cnt == 16'h0000)
               begin
                  n.rem = s.pj_dist;
                  n.st  = ST_PJ_MOVE;
               end
               else
                  n.wait_cnt = s.wait_cnt - 16'h0001;
            end
            ST_OFS_CMD, ST_OFS_CUR:
            begin
               // Averaging over sixteen cycles rejects converter noise
               n.sum_a = s.sum_a + {{4{analog_cmd[15]}}, analog_cmd};
               n.sum_b = s.sum_b + {{4{cur_u_adc[15]}}, cur_u_adc};
               if (s.st == ST_OFS_CUR)
                  n.sum_a = s.sum_a + {{4{cur_v_adc[15]}}, cur_v_adc};
               n.samp = s.samp + 5'h01;
               if (n.samp == `SAX_OFS_SAMPLES)
               begin
                  if (s.st == ST_OFS_CMD)
                  begin
                     n.ofs.spd = n.sum_a[19:4];
                  end
                  else
                  begin
                     n.ofs.cur_v = n.sum_a[19:4];
                     n.ofs.cur_u = n.sum_b[19:4];
                  end
                  n.nv_store = 1'b1;
                  n.st = ST_IDLE;
               end
            end
            default: n.st = ST_IDLE;
         endcase
      end

      // =====================================================
      // Function requests
      if (cmd_go)
      begin
         unique case (sax_cmd_t'(pwdata[3:0]))
            CMD_STOP:
            begin
               n.stopping = 1'b1;
               if (s.st == ST_PJ_WAIT)
                  n.st = ST_IDLE;
            end
            CMD_RESTORE:
            begin
               if (servo_on || s.st != ST_IDLE)
                  n.refused = 1'b1;
               else
               begin
                  // Only the stored image changes; live values stay
                  n.refused      = 1'b0;
                  n.nv_restore   = 1'b1;
                  n.restore_pend = 1'b1;
               end
            end
            CMD_JOG_FWD, CMD_JOG_REV, CMD_PJOG:
            begin
               if (s.st != ST_IDLE || !servo_on || motor_running)
                  n.refused = 1'b1;
               else
               begin
                  n.refused  = 1'b0;
                  n.stopping = 1'b0;
                  n.vel      = 32'h0000_0000;
                  n.dir      = (pwdata[3:0] == CMD_JOG_REV);
                  n.st       = ST_JOG;
                  if (pwdata[3:0] == CMD_PJOG)
                  begin
                     n.dir = (s.pj_mode == 2'b01);
                     n.rem = s.pj_dist;
                     n.rep = s.pj_cnt;
                     n.st  = ST_PJ_MOVE;
                  end
               end
            end
            CMD_OFS_CMD, CMD_OFS_CUR:
            begin
               if (servo_on || s.st != ST_IDLE)
                  n.refused = 1'b1;
               else
               begin
                  n.refused = 1'b0;
                  n.samp    = 5'h00;
                  n.sum_a   = 20'h0_0000;
                  n.sum_b   = 20'h0_0000;
                  n.st      = (pwdata[3:0] == CMD_OFS_CMD) ? ST_OFS_CMD : ST_OFS_CUR;
               end
            end
            default: n.refused = 1'b1;
         endcase
      end

      // =====================================================
      // Loop steering from the next state
      n.loop.speed_mode    = (n.st == ST_JOG);
      n.loop.pos_mode      = (n.st == ST_PJ_MOVE) || (n.st == ST_PJ_WAIT);
      n.loop.ext_pulse_en  = ~n.loop.pos_mode;
      n.loop.overtravel_en = ~n.loop.speed_mode;
      n.loop.speed_cmd     = (n.loop.pos_mode && n.dir) ? -n.vel[31:16] : n.vel[31:16];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s         <= '0;
         s.accel   <= `SAX_RST_ACCEL;
         s.decel   <= `SAX_RST_DECEL;
         s.jog_spd <= `SAX_RST_JOG_SPD;
         s.loop.ext_pulse_en  <= 1'b1;
         s.loop.overtravel_en <= 1'b1;
      end
      else
      begin
         s <= n;
      end
   end

endmodule : sax_aux_top

// [sax_aux_asserts.sv]
// Concurrent checks on the auxiliary block ports
`timescale 1ns/1ps
`include "sax_regs.svh"

module sax_aux_asserts
   import sax_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [13:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        servo_on,
   input wire logic        motor_running,
   input wire sax_loop_t   loop,
   input wire sax_ofs_t    ofs,
   input wire logic        nv_restore
);
   // ==========================================================
   // Decoded writes
   logic        wr;
   logic [11:0] idx;
   logic        cmd_wr;
   logic        jog_wr;
   assign wr     = psel && penable && pready && pwrite;
   assign idx    = paddr[13:2];
   assign cmd_wr = wr && idx == `SAX_IDX_CMD;
   assign jog_wr = cmd_wr && pwdata[3:1] == 3'h1;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // ==========================================================
   // Assertions
   pready_pulse_a : assert property (pready |=> !pready)
      else $error("pready too long");
   restore_cause_a : assert property (nv_restore |-> $past(cmd_wr && pwdata[3:0] == 4'h1 && !servo_on))
      else $error("stray restore");
   restore_ofs_a : assert property (cmd_wr && pwdata[3:0] == 4'h1 |=> $stable(ofs) [*3])
      else $error("restore hit offsets");
   jog_overtravel_a : assert property (loop.speed_mode |-> !loop.overtravel_en)
      else $error("overtravel in jog");
   pjog_guard_a : assert property (loop.pos_mode |-> loop.overtravel_en && !loop.ext_pulse_en)
      else $error("pjog guard");
   jog_busy_a : assert property (jog_wr && motor_running && !loop.speed_mode |=> !loop.speed_mode)
      else $error("jog while running");
   jog_cause_a : assert property ($rose(loop.speed_mode) |-> $past(jog_wr))
      else $error("stray jog");
   jog_limit_a : assert property (loop.speed_mode |-> $signed(loop.speed_cmd) <= 1000 && $signed(loop.speed_cmd) >= -1000)
      else $error("jog speed range");
   ramp_tick_a : assert property (loop.speed_mode && $changed(loop.speed_cmd) |=> $stable(loop.speed_cmd) [*3])
      else $error("ramp off tick");
   spd_ofs_a : assert property (wr && idx == `SAX_IDX_SPD_OFS |=> ofs.spd == $past(pwdata[15:0]) && $stable(ofs.trq))
      else $error("speed offset");
   cur_ofs_a : assert property (wr && idx == `SAX_IDX_CUR_U |=> ofs.cur_u == $past(pwdata[15:0]) && $stable(ofs.cur_v))
      else $error("current offset");

   // ==========================================================
   // Coverage
   cover property (nv_restore);
   cover property ($rose(loop.speed_mode));
   cover property ($rose(loop.pos_mode));
endmodule : sax_aux_asserts

// [sax_motor_model.sv]
// Motor-side stand-in: running flag, analog command and phase current samples
`timescale 1ns/1ps

module sax_motor_model
   import sax_pkg::*;
#(
   parameter logic [15:0] CMD_DRIFT = 16'h0007
)
(
   input  wire logic        servo_on,
   input  wire logic        run_req,
   input  wire sax_loop_t   loop,
   output logic             motor_running,
   output logic      [15:0] analog_cmd,
   output logic      [15:0] cur_u_adc,
   output logic      [15:0] cur_v_adc
);
   // Normal running needs the servo on and no speed jog holding the loop
   assign motor_running = run_req && servo_on && !loop.speed_mode;
   // Servo off: controller holds zero volts, seen only as drift
   assign analog_cmd    = servo_on ? 16'h0400 : CMD_DRIFT;
   assign cur_u_adc     = 16'h0003;
   assign cur_v_adc     = 16'hfffd;
endmodule : sax_motor_model

// [sax_aux_tb_top.sv]
// Self-checking bench for the auxiliary jog and offset block
`timescale 1ns/1ps
`include "sax_regs.svh"

module sax_aux_tb_top;
   import sax_pkg::*;
   localparam int CYC = 8;
   typedef struct {logic [11:0] i; logic [31:0] wd; logic [31:0] rd; logic er;} sax_row_t;

   // ==========================================================
   // Signals
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [13:0] paddr = 14'h0000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        servo_on = 1'b0;
   logic        run_req = 1'b0;
   logic        lim_f = 1'b0;
   logic        lim_r = 1'b0;
   logic        motor_running;
   logic [15:0] analog_cmd;
   logic [15:0] cur_u_adc;
   logic [15:0] cur_v_adc;
   sax_loop_t   loop;
   sax_ofs_t    ofs;
   logic        nv_store;
   logic        nv_restore;
   int          mismatches = 0;
   int          compares = 0;
   int          restores = 0;
   int          n;
   int          t;
   logic [31:0] rd;
   logic        err;
   sax_row_t    rows [10] = '{
      '{`SAX_IDX_ACCEL, 32'h3000, 32'h2710, 1'b0},
      '{`SAX_IDX_ACCEL, 32'h64, 32'h64, 1'b0},
      '{`SAX_IDX_DECEL, 32'h2710, 32'h2710, 1'b0},
      '{`SAX_IDX_DECEL, 32'hc8, 32'hc8, 1'b0},
      '{`SAX_IDX_JOG_SPD, 32'h3e9, 32'h3e8, 1'b0},
      '{`SAX_IDX_SPD_OFS, 32'h12, 32'h12, 1'b0},
      '{`SAX_IDX_TRQ_OFS, 32'hfff0, 32'hfff0, 1'b0},
      '{`SAX_IDX_CUR_U, 32'h5, 32'h5, 1'b0},
      '{`SAX_IDX_CUR_V, 32'h7, 32'h7, 1'b0},
      '{12'h7ff, 32'h1234, 32'h0, 1'b1}};

   always #2.5 pclk = ~pclk;
   always @(posedge pclk) if (nv_restore === 1'b1) restores++;

   sax_aux_top #(.CTRL_CYC(CYC)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .servo_on(servo_on),
      .motor_running(motor_running), .analog_cmd(analog_cmd), .cur_u_adc(cur_u_adc),
      .cur_v_adc(cur_v_adc), .limit_fwd_pin(lim_f), .limit_rev_pin(lim_r),
      .loop(loop), .ofs(ofs), .nv_store(nv_store), .nv_restore(nv_restore));

   sax_motor_model i_motor (.servo_on(servo_on), .run_req(run_req), .loop(loop),
      .motor_running(motor_running), .analog_cmd(analog_cmd),
      .cur_u_adc(cur_u_adc), .cur_v_adc(cur_v_adc));

   // ==========================================================
   // Tasks
   task check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask : check

   // Bus request held until pready is seen high at a rising edge
   task apb(input logic w, input logic [11:0] i, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= {i, 2'b00};
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      check({31'h0, pready}, 32'h1);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task st_rd();
      apb(1'b0, `SAX_IDX_STATUS, 32'h0);
   endtask : st_rd

   task do_reset();
      presetn <= 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
   endtask : do_reset

   task wait_spd(input logic [15:0] v);
      t = 0;
      while (loop.speed_cmd !== v && t < 200 * CYC)
      begin
         @(posedge pclk);
         t++;
      end
   endtask : wait_spd

   task final_report();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : final_report

   // ==========================================================
   // Tests
   initial
   begin
      do_reset();
      foreach (rows[k])
      begin
         apb(1'b1, rows[k].i, rows[k].wd);
         apb(1'b0, rows[k].i, 32'h0);
         check(rd, rows[k].rd);
         check({31'h0, err}, {31'h0, rows[k].er});
      end
      $display("test registers done");
      servo_on <= 1'b1;
      run_req  <= 1'b1;
      apb(1'b1, `SAX_IDX_CMD, 32'h2);
      st_rd();
      check({28'h0, rd[3:0]}, 32'h8);
      run_req <= 1'b0;
      // 3000 rpm per 100 ms up and per 200 ms down gives 30 rpm a tick up, 15 a tick down
      for (int c = 2; c < 4; c++)
      begin
         apb(1'b1, `SAX_IDX_CMD, 32'(c));
         wait_spd(c == 2 ? 16'h03e8 : 16'hfc18);
         check({31'h0, t >= 33 * CYC && t <= 35 * CYC}, 32'h1);
         check({30'h0, loop.speed_mode, loop.overtravel_en}, 32'h2);
         apb(1'b1, `SAX_IDX_CMD, 32'h0);
         wait_spd(16'h0000);
         check({31'h0, t >= 65 * CYC && t <= 68 * CYC}, 32'h1);
      end
      $display("test jog done");
      apb(1'b1, `SAX_IDX_CMD, 32'h1);
      st_rd();
      check({27'h0, rd[4:0]}, 32'h8);
      servo_on <= 1'b0;
      apb(1'b1, `SAX_IDX_CMD, 32'h1);
      st_rd();
      check({27'h0, rd[4:0]}, 32'h10);
      check(32'(restores), 32'h1);
      apb(1'b0, `SAX_IDX_JOG_SPD, 32'h0);
      check(rd, 32'h3e8);
      check({ofs.spd, ofs.cur_v}, 32'h0012_0007);
      $display("test restore done");
      for (int c = 5; c < 7; c++)
      begin
         apb(1'b1, `SAX_IDX_CMD, 32'(c));
         n = 0;
         while (nv_store !== 1'b1 && n < 40 * CYC)
         begin
            @(posedge pclk);
            n++;
         end
         check({31'h0, nv_store}, 32'h1);
         @(posedge pclk);
         if (c == 5)
            check({16'h0, ofs.spd}, 32'h7);
         else
            check({ofs.cur_u, ofs.cur_v}, 32'h0003_fffd);
      end
      $display("test offsets done");
      servo_on <= 1'b1;
      apb(1'b1, `SAX_IDX_PJ_DIST, 32'h100);
      apb(1'b1, `SAX_IDX_PJ_SPD, 32'h10);
      apb(1'b1, `SAX_IDX_PJ_CNT, 32'h0002_0003);
      apb(1'b1, `SAX_IDX_CMD, 32'h4);
      // Loop outputs update on the edge that completes the command write; sample them at the next edge
      @(posedge pclk);
      check({29'h0, loop.pos_mode, loop.ext_pulse_en, loop.overtravel_en}, 32'h5);
      lim_f <= 1'b1;
      n = 0;
      do
      begin
         st_rd();
         n++;
      end
      while (rd[2:0] !== 3'h0 && n < 10);
      // Restore pending stays set until the next reset
      check({25'h0, rd[6:0]}, 32'h30);
      lim_f <= 1'b0;
      $display("test programmed jog done");
      do_reset();
      check({30'h0, loop.ext_pulse_en, loop.overtravel_en}, 32'h3);
      apb(1'b0, `SAX_IDX_ACCEL, 32'h0);
      check(rd, 32'h0);
      apb(1'b0, `SAX_IDX_DECEL, 32'h0);
      check(rd, 32'h0);
      apb(1'b0, `SAX_IDX_JOG_SPD, 32'h0);
      check(rd, 32'h1f4);
      st_rd();
      check({27'h0, rd[4:0]}, 32'h0);
      $display("test reset done");
      final_report();
   end

   initial
   begin
      #(60000 * 5);
      mismatches++;
      final_report();
   end
endmodule : sax_aux_tb_top

bind sax_aux_top sax_aux_asserts i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .servo_on(servo_on), .motor_running(motor_running), .loop(loop), .ofs(ofs),
   .nv_restore(nv_restore));
